// >>> psms_map.svh
`ifndef PSMS_MAP_SVH
`define PSMS_MAP_SVH

// ****************************************
// Register offsets (8-bit index space)
// ****************************************
`define PSMS_IDLE_ENABLE_OFS 8'h81
`define PSMS_TRAP_ENABLE_OFS 8'h83
`define PSMS_IDLE_MIRROR_OFS 8'h85
`define PSMS_IDLE_STATUS_OFS 8'hF5
`define PSMS_TRAP_STATUS_OFS 8'hF6
`define PSMS_IRQ_STATUS_OFS 8'hE0
`define PSMS_IRQ_MASK_OFS 8'hE1
`define PSMS_TOP_STATUS_OFS 8'hE2

// ****************************************
// Field positions and reset values
// ****************************************
`define PSMS_IDLE_BITS 5
`define PSMS_IDLE_MASK 8'h1F
`define PSMS_VIDEO_TRAP_BIT 7
`define PSMS_RESET_BYTE 8'h00

`endif

// >>> psms_pkg.sv
package psms_pkg;
    typedef logic [7:0] psms_byte_type;
    typedef logic [4:0] psms_idle_type;
endpackage

// >>> psms_sticky.sv
`include "psms_map.svh"

module psms_sticky (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Set and clear
    input wire logic set_i,
    input wire logic clear_i,
    // State
    output logic flag_o
);
    // Set wins over a simultaneous clear so no event is lost
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= set_i | (flag_o & ~clear_i);
        end
    end
endmodule

// >>> psms_status.sv
// Operation
// R1 - User device one idle expiry sets bit 4
// R2 - Keyboard/mouse idle expiry sets bit 3
// R3 - Parallel/serial idle expiry sets bit 2
// R4 - Floppy idle expiry sets bit 1
// R5 - Primary disk idle expiry sets bit 0
// R6 - Read returns bits then clears them
// R7 - Set only on full idle expiry
// R8 - Any set bit raises top summary
// R9 - Video trap sets bit 7, clear-on-read
// R10 - Mirror at 85h reads without clearing
// R11 - Video trap gated by enable bit 7
// R12 - Event during clearing read is kept
// R13 - SMI drops when all bits clear
//
// The strobed register port was decided locally.
`include "psms_map.svh"

module psms_status
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output psms_pkg::psms_byte_type reg_rdata_o,
    // Events from timers and trap decoder (same clock)
    input wire logic [4:0] idle_expired_i,
    input wire logic video_trap_i,
    // Interrupt and summary
    output logic smi_o,
    output logic top_smi_status_o,
    output logic irq_o
);
    import psms_pkg::*;

    // ****************************************
    // Decode
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    psms_byte_type idle_enable;
    psms_byte_type trap_enable;
    psms_byte_type irq_mask;
    psms_idle_type idle_flag;
    logic trap_flag;
    logic irq_sticky;

    wire wr_idle_en = reg_wr_i & hit(reg_addr_i, `PSMS_IDLE_ENABLE_OFS);
    wire wr_trap_en = reg_wr_i & hit(reg_addr_i, `PSMS_TRAP_ENABLE_OFS);
    wire wr_irq_mask = reg_wr_i & hit(reg_addr_i, `PSMS_IRQ_MASK_OFS);
    wire wr_irq_stat = reg_wr_i & hit(reg_addr_i, `PSMS_IRQ_STATUS_OFS);
    wire rd_idle = reg_rd_i & hit(reg_addr_i, `PSMS_IDLE_STATUS_OFS);
    wire rd_trap = reg_rd_i & hit(reg_addr_i, `PSMS_TRAP_STATUS_OFS);

    // Events qualified by their enables
    wire [4:0] idle_set = idle_expired_i & idle_enable[4:0]; // R1 R2 R3 R4 R5 R7
    wire trap_set = video_trap_i & trap_enable[`PSMS_VIDEO_TRAP_BIT]; // R9 R11
    wire any_flag = (|idle_flag) | trap_flag; // R8

    // ****************************************
    // Status bits
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < `PSMS_IDLE_BITS; gi++) begin : g_idle
            psms_sticky u_bit (
                .ref_clk_i(ref_clk_i),
                .resetn_i(resetn_i),
                .set_i(idle_set[gi]),
                .clear_i(rd_idle), // R6 R12
                .flag_o(idle_flag[gi])
            );
        end
    endgenerate

    psms_sticky u_trap (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .set_i(trap_set),
        .clear_i(rd_trap), // R9 R12
        .flag_o(trap_flag)
    );

    // ****************************************
    // Read data mux
    // ****************************************
    wire [7:0] idle_byte = {3'b000, idle_flag};
    wire [7:0] trap_byte = {trap_flag, 7'b000_0000};
    wire [7:0] rd_mux =
        hit(reg_addr_i, `PSMS_IDLE_STATUS_OFS) ? idle_byte : // R6
        hit(reg_addr_i, `PSMS_IDLE_MIRROR_OFS) ? idle_byte : // R10
        hit(reg_addr_i, `PSMS_TRAP_STATUS_OFS) ? trap_byte :
        hit(reg_addr_i, `PSMS_IDLE_ENABLE_OFS) ? idle_enable :
        hit(reg_addr_i, `PSMS_TRAP_ENABLE_OFS) ? trap_enable :
        hit(reg_addr_i, `PSMS_IRQ_STATUS_OFS) ? {7'b000_0000, irq_sticky} :
        hit(reg_addr_i, `PSMS_IRQ_MASK_OFS) ? irq_mask :
        hit(reg_addr_i, `PSMS_TOP_STATUS_OFS) ? {7'b000_0000, any_flag} :
        8'h00;

    // ****************************************
    // Registers and outputs
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            idle_enable <= `PSMS_RESET_BYTE;
            trap_enable <= `PSMS_RESET_BYTE;
            irq_mask <= `PSMS_RESET_BYTE;
            irq_sticky <= 1'b0;
            reg_rdata_o <= `PSMS_RESET_BYTE;
            smi_o <= 1'b0;
            top_smi_status_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            if (wr_idle_en) begin
                idle_enable <= reg_wdata_i & `PSMS_IDLE_MASK;
            end
            if (wr_trap_en) begin
                trap_enable <= reg_wdata_i;
            end
            if (wr_irq_mask) begin
                irq_mask <= reg_wdata_i;
            end
            // New event beats write-one-to-clear
            irq_sticky <= ((|idle_set) | trap_set)
                | (irq_sticky & ~(wr_irq_stat & reg_wdata_i[0]));
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
            // Registered, so SMI trails the flags by one cycle
            smi_o <= any_flag; // R13
            top_smi_status_o <= any_flag; // R8
            irq_o <= irq_sticky & irq_mask[0];
        end
    end

    // ****************************************
    // Check helpers
    // ****************************************
    wire rd_mirror = reg_rd_i & hit(reg_addr_i, `PSMS_IDLE_MIRROR_OFS);
    wire rd_top = reg_rd_i & hit(reg_addr_i, `PSMS_TOP_STATUS_OFS);
    wire rd_irq_stat = reg_rd_i & hit(reg_addr_i, `PSMS_IRQ_STATUS_OFS);
    wire wr_idle_stat = reg_wr_i & hit(reg_addr_i, `PSMS_IDLE_STATUS_OFS);
    wire wr_trap_stat = reg_wr_i & hit(reg_addr_i, `PSMS_TRAP_STATUS_OFS);
    wire any_set = (|idle_set) | trap_set;

    // ****************************************
    // Checks: idle status bits
    // ****************************************
    AST_IDLE_SET: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1
        idle_expired_i[4] && idle_enable[4] |=> idle_flag[4])
        else $error("idle bit 4 not set");

    AST_BIT4_GATE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1
        !idle_flag[4] && !(idle_expired_i[4] && idle_enable[4]) |=> !idle_flag[4])
        else $error("idle bit 4 set without enabled event");

    AST_BIT3_SET: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R2
        idle_expired_i[3] && idle_enable[3] |=> idle_flag[3])
        else $error("idle bit 3 not set");

    AST_IDLE_GATE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R2
        !idle_flag[3] && !(idle_expired_i[3] && idle_enable[3]) |=> !idle_flag[3])
        else $error("idle bit 3 set without enabled event");

    AST_BIT2: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R3
        idle_expired_i[2] && idle_enable[2] |=> idle_flag[2])
        else $error("idle bit 2 not set");

    AST_BIT2_GATE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R3
        !idle_flag[2] && !(idle_expired_i[2] && idle_enable[2]) |=> !idle_flag[2])
        else $error("idle bit 2 set without enabled event");

    AST_BIT1: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R4
        idle_expired_i[1] && idle_enable[1] |=> idle_flag[1])
        else $error("idle bit 1 not set");

    AST_BIT1_GATE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R4
        !idle_flag[1] && !(idle_expired_i[1] && idle_enable[1]) |=> !idle_flag[1])
        else $error("idle bit 1 set without enabled event");

    AST_BIT0: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R5
        idle_expired_i[0] && idle_enable[0] |=> idle_flag[0])
        else $error("idle bit 0 not set");

    AST_BIT0_GATE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R5
        !idle_flag[0] && !(idle_expired_i[0] && idle_enable[0]) |=> !idle_flag[0])
        else $error("idle bit 0 set without enabled event");

    AST_ENABLE_WRITE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1
        wr_idle_en |=> idle_enable == ($past(reg_wdata_i) & `PSMS_IDLE_MASK))
        else $error("idle enable write lost");

    // Upper enable bits have no source behind them
    AST_ENABLE_UPPER: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1
        idle_enable[7:5] == 3'h0)
        else $error("unused idle enable bits set");

    AST_ENABLE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1
        !wr_idle_en |=> idle_enable == $past(idle_enable))
        else $error("idle enable changed without write");

    // ****************************************
    // Checks: clearing read and mirror
    // ****************************************
    AST_READ_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R6
        rd_idle && !(|idle_set) |=> idle_flag == 5'b00000 && reg_rdata_o == $past(idle_byte))
        else $error("clearing read wrong");

    // Only the bits raised in the read cycle survive it
    AST_READ_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R12
        rd_idle && (|idle_set) |=> idle_flag == $past(idle_set))
        else $error("idle event lost in clearing read");

    AST_IDLE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R6
        !rd_idle |=> ((idle_flag & $past(idle_flag)) == $past(idle_flag)))
        else $error("idle bit dropped without clearing read");

    AST_STATUS_RO: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R6
        wr_idle_stat && !reg_rd_i && !(|idle_set) |=> idle_flag == $past(idle_flag))
        else $error("idle status changed by write");

    AST_RDATA_IDLE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R6
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data without read strobe");

    AST_IDLE_BYTE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R6
        rd_idle |=> reg_rdata_o[7:5] == 3'h0)
        else $error("idle status upper bits set");

    AST_MIRROR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R10
        reg_rd_i && hit(reg_addr_i, `PSMS_IDLE_MIRROR_OFS) |=> idle_flag == $past(idle_flag)
        || (|$past(idle_set)))
        else $error("mirror read disturbed bits");

    AST_MIRROR_DATA: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R10
        rd_mirror |=> reg_rdata_o == $past(idle_byte))
        else $error("mirror read data wrong");

    AST_MIRROR_SMI: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R10
        rd_mirror && (|idle_flag) |=> ##1 smi_o)
        else $error("mirror read dropped smi");

    // ****************************************
    // Checks: video trap
    // ****************************************
    AST_TRAP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R11
        video_trap_i && !trap_enable[7] && !trap_flag |=> !trap_flag)
        else $error("trap set while disabled");

    AST_TRAP_LOW: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R11
        !trap_flag && !trap_set |=> !trap_flag)
        else $error("trap set without enabled event");

    AST_TRAP_SET: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R9
        trap_set |=> trap_flag)
        else $error("trap bit not set");

    AST_TRAP_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R9
        trap_flag && !rd_trap |=> trap_flag)
        else $error("trap bit dropped without clearing read");

    AST_TRAP_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R9
        rd_trap && !trap_set |=> !trap_flag
        && reg_rdata_o == $past(trap_byte))
        else $error("trap clearing read wrong");

    AST_TRAP_BYTE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R9
        rd_trap |=> reg_rdata_o[6:0] == 7'h00)
        else $error("trap status low bits set");

    AST_TRAP_RO: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R9
        wr_trap_stat && !trap_set |=> trap_flag == $past(trap_flag))
        else $error("trap status changed by write");

    AST_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R12
        rd_trap && trap_set |=> trap_flag)
        else $error("event lost in clearing read");

    AST_TRAP_EN_WRITE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R11
        wr_trap_en |=> trap_enable == $past(reg_wdata_i))
        else $error("trap enable write lost");

    // ****************************************
    // Checks: summary and SMI
    // ****************************************
    AST_SMI: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R8
        any_flag |=> smi_o && top_smi_status_o)
        else $error("summary not raised");

    AST_TOP_SMI: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R8
        top_smi_status_o == smi_o)
        else $error("summary and smi differ");

    AST_SMI_RISE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R8
        $rose(smi_o) |-> $past(any_flag))
        else $error("smi raised with no status bit");

    AST_SUMMARY_READ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R8
        rd_top |=> reg_rdata_o == {7'h00, $past(any_flag)})
        else $error("summary read data wrong");

    AST_SMI_DROP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R13
        !any_flag |=> !smi_o)
        else $error("smi held with no flags");

    // Two cycles: one to clear the flags, one for the registered SMI
    AST_SMI_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R13
        rd_idle && !trap_flag && !any_set
        |=> ##1 !smi_o)
        else $error("smi held after last bit cleared");

    AST_RESET_CLEAN: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R9
        !$past(resetn_i) |-> idle_flag == 5'h00 && !trap_flag && !smi_o && !irq_o
        && reg_rdata_o == 8'h00)
        else $error("state not clean after reset");

    // ****************************************
    // Checks: interrupt
    // ****************************************
    AST_IRQ_SET: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1 R9
        any_set |=> irq_sticky)
        else $error("irq status not set");

    AST_IRQ_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R12
        any_set && wr_irq_stat |=> irq_sticky)
        else $error("irq event lost in clearing write");

    AST_IRQ_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R12
        wr_irq_stat && reg_wdata_i[0] && !any_set |=> !irq_sticky)
        else $error("irq status not cleared");

    AST_IRQ_READ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1 R9
        rd_irq_stat |=> reg_rdata_o == {7'h00, $past(irq_sticky)})
        else $error("irq status read data wrong");

    AST_IRQ_OUT: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1 R9
        irq_sticky && irq_mask[0] |=> irq_o)
        else $error("irq not raised");

    AST_IRQ_MASKED: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1 R9
        !irq_mask[0] |=> !irq_o)
        else $error("irq raised while masked");

    AST_MASK_WRITE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1 R9
        wr_irq_mask |=> irq_mask == $past(reg_wdata_i))
        else $error("irq mask write lost");
endmodule

// >>> psms_status_tb.sv
module psms_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import psms_pkg::*;
    // ************************************
    // Stimulus and model state
    // ************************************
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [4:0] idle_expired_i = 5'h00;
    logic video_trap_i = 1'b0;
    psms_byte_type reg_rdata_o;
    logic smi_o;
    logic top_smi_status_o;
    logic irq_o;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32'h5ca7_6bba;
    int m_idle, m_trap, m_en, m_ten, m_sticky, m_mask, m_rdata, set_idle, set_trap;
    logic m_smi;
    logic [7:0] addr_tab [10] = '{8'h81, 8'h83, 8'h85, 8'hF5, 8'hF6, 8'hE0, 8'hE1, 8'h40,
                                 8'hF5, 8'hE2};

    always #5 ref_clk_i = ~ref_clk_i;

    psms_status DUT (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .idle_expired_i(idle_expired_i),
        .video_trap_i(video_trap_i),
        .smi_o(smi_o),
        .top_smi_status_o(top_smi_status_o),
        .irq_o(irq_o)
    );

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic wrap_up;
        if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************
    // Reference model, same edge as design
    // ************************************
    always @(posedge ref_clk_i) begin
        // Enables sampled before any write lands in this cycle
        set_idle = idle_expired_i & m_en;
        set_trap = (video_trap_i && m_ten[7]) ? 8'h80 : 8'h00;
        if (!resetn_i) begin
            {m_idle, m_trap, m_en, m_ten, m_sticky, m_mask, m_rdata} = '0;
            m_smi = 1'b0;
        end else begin
            m_rdata = 0;
            m_smi = (m_idle | m_trap) != 0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    8'h81: m_rdata = m_en;
                    8'h83: m_rdata = m_ten;
                    8'h85, 8'hF5: m_rdata = m_idle;
                    8'hF6: m_rdata = m_trap;
                    8'hE0: m_rdata = m_sticky;
                    8'hE1: m_rdata = m_mask;
                    8'hE2: m_rdata = m_smi;
                    default: m_rdata = 0;
                endcase
                if (reg_addr_i == 8'hF5) m_idle = 0;
                if (reg_addr_i == 8'hF6) m_trap = 0;
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                    8'h81: m_en = reg_wdata_i & 8'h1F;
                    8'h83: m_ten = reg_wdata_i;
                    8'hE0: if (reg_wdata_i[0]) m_sticky = 0;
                    8'hE1: m_mask = reg_wdata_i;
                    default: ;
                endcase
            end
            // New events win over a clearing read or write
            m_idle |= set_idle;
            m_trap |= set_trap;
            if ((set_idle | set_trap) != 0) m_sticky = 1;
        end
    end

    always @(negedge ref_clk_i) begin
        if (resetn_i) begin
            chk8("rdata", 8'(m_rdata), reg_rdata_o);
            chk1("smi", m_smi, smi_o);
            chk1("top", m_smi, top_smi_status_o);
        end
    end

    // ************************************
    // Random traffic, settle, check irq
    // ************************************
    task automatic step(input bit quiet);
        int r;
        r = $random(seed);
        @(posedge ref_clk_i);
        idle_expired_i <= quiet ? 5'h00 : 5'($random(seed)) & 5'($random(seed));
        video_trap_i <= !quiet && r[3:2] == 2'h0;
        reg_rd_i <= !quiet && r[1:0] == 2'h1;
        reg_wr_i <= !quiet && r[1:0] == 2'h2;
        reg_addr_i <= addr_tab[r[7:4] % 10];
        reg_wdata_i <= 8'($random(seed));
    endtask

    initial begin
        repeat (4) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        for (int p = 0; p < 100; p++) begin
            repeat (40) step(1'b0);
            repeat (4) step(1'b1);
            @(negedge ref_clk_i);
            chk1("irq", 1'(m_sticky & m_mask), irq_o);
        end
        wrap_up();
    end
endmodule
